// [pkg/isx_pkg.sv]
// Constants for the serial-bus auxiliary block: register map, fields, timing
//------------------------------------------------------------
// Notes on behaviour
// - Transmit: empty plus byte-complete holds clock low until data written.
// - Receive: not-empty plus byte-complete holds clock low until data read.
// - Slave stretch-disable stops stretching; late service flags overrun/underrun.
// - DMA enabled: each empty or not-empty assertion issues one DMA request.
// - DMA set up before transfer; signals end of transfer on completion.
// - Master DMA receive with last-bit set NACKs final byte after end of transfer.
// - Checksum is CRC-8, polynomial x8+x2+x+1, starting from zero.
// - With checksum enabled every bus byte, address included, is accumulated.
// - Checksum-transfer sends computed value, or compares received checksum byte.
// - DMA with both checksum bits set sends or checks checksum at end.
// - SMBus mode: clock low beyond 25 ms is a timeout error.
// - SMBus clock never below 10 kHz so stretching cannot lock bus.
// - Address resolution raises host or default-device flag per configured role.
// - SMBus mode: alert line activity raises the alert flag; the code raises it only while frame mode is off.
// - Master mode: frame output asserted while controller is busy.
// - Frame input shares its pin with the SMBus alert line.
// - Frame mode enable gates frame level status and edge flags.
// - Event flags: start, address, header, stop, byte, empty, not-empty, frame edges.
// - Error flags: bus, arbitration, overrun, no-ack, checksum, timeout, alert.
// - Interrupt asserted for any flag whose enable bit is set; the code leaves the address-resolution flags out of both interrupts.
// - SMBus timeout sets the stop-request bit in hardware.
// - Checksum-transfer cleared after checksum byte, on start/stop, or when disabled.
//------------------------------------------------------------
package isx_pkg;
  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL0 = 8'h00;
  localparam logic [7:0] ADDR_CTRL1 = 8'h04;
  localparam logic [7:0] ADDR_STAT0 = 8'h08;
  localparam logic [7:0] ADDR_STAT1 = 8'h0C;
  localparam logic [7:0] ADDR_FRAME = 8'h10;
  localparam logic [15:0] CTRL0_RESET = 16'h0000;
  localparam logic [15:0] CTRL1_RESET = 16'h0000;
  localparam logic [7:0] FRAME_RESET = 8'h00;
  // Control 0 fields
  localparam int C0_ENABLE = 0;
  localparam int C0_SMBUS = 1;
  localparam int C0_ROLE = 3;
  localparam int C0_ARP = 4;
  localparam int C0_PEC_EN = 5;
  localparam int C0_NO_STRETCH = 7;
  localparam int C0_STOP = 9;
  localparam int C0_ACK = 10;
  localparam int C0_PEC_TX = 12;
  localparam int C0_ALERT = 13;
  // Control 1 fields
  localparam int C1_ERR_IE = 8;
  localparam int C1_EVT_IE = 9;
  localparam int C1_DMA_ON = 11;
  localparam int C1_DMA_LAST = 12;
  // Status: events in [7:0], errors in [15:8]; status 1: arp [6:5], checksum [15:8]
  localparam int ST_EVT_LSB = 0;
  localparam int ST_ERR_LSB = 8;
  localparam int S1_DEFAULT = 5;
  localparam int S1_HOST = 6;
  localparam int S1_PEC_LSB = 8;
  // Frame control/status fields; edge flags in [7:4]
  localparam int FR_ENABLE = 0;
  localparam int FR_IN_LEVEL = 2;
  localparam int FR_OUT_LEVEL = 3;
  localparam int FR_EDGE_LSB = 4;
  // Bus answers and checksum
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [7:0] CRC_INIT = 8'h00;
  // Timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int TIMEOUT_MS = 25;
  localparam int NS_PER_MS = 1000000;
  localparam int TIMEOUT_CYC = (TIMEOUT_MS * NS_PER_MS) / CLK_PERIOD_NS;
endpackage : isx_pkg

// [verilog/isx_aux.sv]
// Stretching, DMA, checksum, SMBus and frame-signal logic of the serial bus controller
//
// Design decisions made here: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/10ps
module isx_aux #(
  parameter int unsigned TIMEOUT_CYCLES = isx_pkg::TIMEOUT_CYC
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Byte engine state, same clock
  input wire logic eng_transmitting,
  input wire logic eng_master,
  input wire logic eng_busy,
  input wire logic tx_empty_flag,
  input wire logic rx_not_empty_flag,
  input wire logic byte_complete_flag,
  // Byte engine events, one-cycle pulses
  input wire logic ev_start_sent,
  input wire logic ev_address_matched,
  input wire logic ev_header_sent,
  input wire logic ev_stop_detected,
  input wire logic ev_start_detected,
  input wire logic ev_bus_error,
  input wire logic ev_arb_lost,
  input wire logic ev_nack,
  input wire logic ev_host_address,
  input wire logic ev_default_address,
  input wire logic bus_byte_valid,
  input wire logic [7:0] bus_byte,
  input wire logic pec_byte_valid,
  input wire logic [7:0] pec_byte,
  // Controls back to the byte engine
  output logic eng_ack_enable,
  output logic eng_checksum_send,
  output logic [7:0] checksum_value,
  output logic stop_request,
  // DMA controller
  output logic dma_tx_req,
  output logic dma_rx_req,
  input wire logic dma_eot,
  // Pins: clock line, alert/frame-in line, frame out
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe_n,
  input wire logic smba_in,
  output logic smba_out,
  output logic smba_oe_n,
  output logic frame_out,
  // Interrupt lines
  output logic event_irq,
  output logic error_irq
);

  //------------------------------------------------------------
  // Helpers
  //------------------------------------------------------------
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return res;
  endfunction : merge

  function automatic logic [7:0] sticky(input logic [7:0] cur, input logic [7:0] set,
                                        input logic [7:0] clr);
    // Set beats a clear that lands in the same cycle
    return (cur & ~clr) | set;
  endfunction : sticky

  function automatic logic [7:0] crc8_step(input logic [7:0] crc, input logic [7:0] din);
    logic [7:0] c;
    c = crc ^ din;
    for (int i = 0; i < 8; i++) begin
      c = c[7] ? ((c << 1) ^ isx_pkg::CRC_POLY) : (c << 1);
    end
    return c;
  endfunction : crc8_step

  //------------------------------------------------------------
  // Registers and synchronisers
  //------------------------------------------------------------
  logic [15:0] ctrl0;
  logic [15:0] ctrl1;
  logic [15:0] next_ctrl0;
  logic [15:0] next_ctrl1;
  logic [7:0] frame_ctl;
  logic [7:0] ev_flags;
  logic [7:0] err_flags;
  logic [7:0] fr_flags;
  logic [7:0] arp_flags;
  logic [7:0] crc;
  logic eot_seen;
  logic scl_meta, scl_sync, scl_prev;
  logic smba_meta, smba_sync, smba_prev;
  logic frame_out_prev;
  logic tx_req_prev, rx_req_prev;
  logic [20:0] tmo_cnt;
  logic aw_full, w_full;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scl_meta <= 1'b1;
      scl_sync <= 1'b1;
      scl_prev <= 1'b1;
      smba_meta <= 1'b1;
      smba_sync <= 1'b1;
      smba_prev <= 1'b1;
    end else begin
      scl_meta <= scl_in;
      scl_sync <= scl_meta;
      scl_prev <= scl_sync;
      smba_meta <= smba_in;
      smba_sync <= smba_meta;
      smba_prev <= smba_sync;
    end
  end

  //------------------------------------------------------------
  // Decoded controls
  //------------------------------------------------------------
  wire enabled = ctrl0[isx_pkg::C0_ENABLE];
  wire smbus = ctrl0[isx_pkg::C0_SMBUS];
  wire dma_on = ctrl1[isx_pkg::C1_DMA_ON];
  wire frame_en = frame_ctl[isx_pkg::FR_ENABLE];
  wire slave_no_stretch = !eng_master && ctrl0[isx_pkg::C0_NO_STRETCH];
  wire scl_fall = scl_prev && !scl_sync;
  wire tx_stall = eng_transmitting && tx_empty_flag && byte_complete_flag;
  wire rx_stall = !eng_transmitting && rx_not_empty_flag && byte_complete_flag;
  wire stretch = (tx_stall || rx_stall) && !slave_no_stretch;
  wire overrun = slave_no_stretch && (tx_stall || rx_stall) && scl_fall;
  wire tx_req_cond = dma_on && eng_transmitting && tx_empty_flag;
  wire rx_req_cond = dma_on && !eng_transmitting && rx_not_empty_flag;
  wire last_nack = ctrl1[isx_pkg::C1_DMA_LAST] && eot_seen && eng_master
                   && !eng_transmitting;
  wire pec_arm = ctrl0[isx_pkg::C0_PEC_EN] && ctrl0[isx_pkg::C0_PEC_TX]
                 && (!dma_on || eot_seen);
  wire pec_clr = pec_byte_valid || ev_start_detected || ev_stop_detected || !enabled;
  wire crc_bad = pec_byte_valid && !eng_transmitting && ctrl0[isx_pkg::C0_PEC_TX]
                 && (pec_byte != crc);
  wire tmo_low = smbus && !scl_sync;
  wire tmo_hit = tmo_low && (tmo_cnt == 21'(TIMEOUT_CYCLES - 1));
  wire alert_seen = smbus && !frame_en && smba_prev && !smba_sync;
  wire frame_level = frame_en && eng_master && eng_busy;
  wire in_rise = frame_en && !smba_prev && smba_sync;
  wire in_fall = frame_en && smba_prev && !smba_sync;
  wire out_rise = frame_level && !frame_out_prev;
  wire out_fall = !frame_level && frame_out_prev && frame_en;

  //------------------------------------------------------------
  // AXI4-Lite slave
  //------------------------------------------------------------
  wire wr_fire = aw_full && w_full && !bvalid;
  wire sel_c0 = aw_addr == isx_pkg::ADDR_CTRL0;
  wire sel_c1 = aw_addr == isx_pkg::ADDR_CTRL1;
  wire sel_s0 = aw_addr == isx_pkg::ADDR_STAT0;
  wire sel_s1 = aw_addr == isx_pkg::ADDR_STAT1;
  wire sel_fr = aw_addr == isx_pkg::ADDR_FRAME;
  wire wr_hit = sel_c0 || sel_c1 || sel_s0 || sel_s1 || sel_fr;
  wire [31:0] wr_mask = merge(32'h0000_0000, 32'hFFFF_FFFF, w_strb);
  // Status bits clear where software writes a zero
  wire [31:0] wr_zero = wr_mask & ~w_data;
  wire [7:0] clr_evt = (wr_fire && sel_s0) ? wr_zero[isx_pkg::ST_EVT_LSB +: 8] : 8'h00;
  wire [7:0] clr_err = (wr_fire && sel_s0) ? wr_zero[isx_pkg::ST_ERR_LSB +: 8] : 8'h00;
  wire [7:0] clr_arp = (wr_fire && sel_s1) ? wr_zero[7:0] : 8'h00;
  wire [7:0] clr_fr = (wr_fire && sel_fr) ? {wr_zero[7:4], 4'h0} : 8'h00;
  wire [7:0] lvl_evt = {tx_empty_flag, rx_not_empty_flag, 3'h0, byte_complete_flag, 2'h0};
  wire [31:0] rd_stat0 = {16'h0000, err_flags, ev_flags | lvl_evt};
  wire [31:0] rd_stat1 = {16'h0000, crc, arp_flags};
  wire [31:0] rd_frame = {24'h00_0000, fr_flags[7:4], frame_out, smba_sync && frame_en,
                          frame_ctl[1:0]};
  wire ar_fire = arvalid && arready;
  wire rd_hit = araddr == isx_pkg::ADDR_CTRL0 || araddr == isx_pkg::ADDR_CTRL1
                || araddr == isx_pkg::ADDR_STAT0 || araddr == isx_pkg::ADDR_STAT1
                || araddr == isx_pkg::ADDR_FRAME;
  wire [31:0] rd_mux = (araddr == isx_pkg::ADDR_CTRL0) ? {16'h0000, ctrl0} :
                       (araddr == isx_pkg::ADDR_CTRL1) ? {16'h0000, ctrl1} :
                       (araddr == isx_pkg::ADDR_STAT0) ? rd_stat0 :
                       (araddr == isx_pkg::ADDR_STAT1) ? rd_stat1 :
                       (araddr == isx_pkg::ADDR_FRAME) ? rd_frame : 32'h0000_0000;

  // Merged write words; a function result cannot be part-selected directly
  wire [31:0] c0_merged = merge({16'h0000, ctrl0}, w_data, w_strb);
  wire [31:0] c1_merged = merge({16'h0000, ctrl1}, w_data, w_strb);
  wire [31:0] fr_merged = merge({24'h00_0000, frame_ctl}, w_data, w_strb);

  assign awready = !aw_full;
  assign wready = !w_full;
  assign arready = !rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      bvalid <= 1'b0;
      bresp <= isx_pkg::RESP_OKAY;
    end else begin
      if (awvalid && !aw_full) begin
        aw_full <= 1'b1;
        aw_addr <= awaddr;
      end else if (wr_fire) begin
        aw_full <= 1'b0;
      end
      if (wvalid && !w_full) begin
        w_full <= 1'b1;
        w_data <= wdata;
        w_strb <= wstrb;
      end else if (wr_fire) begin
        w_full <= 1'b0;
      end
      if (wr_fire) begin
        bvalid <= 1'b1;
        bresp <= wr_hit ? isx_pkg::RESP_OKAY : isx_pkg::RESP_SLVERR;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= isx_pkg::RESP_OKAY;
    end else if (ar_fire) begin
      rvalid <= 1'b1;
      rdata <= rd_mux;
      rresp <= rd_hit ? isx_pkg::RESP_OKAY : isx_pkg::RESP_SLVERR;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  //------------------------------------------------------------
  // Control registers with hardware side effects
  //------------------------------------------------------------
  always_comb begin
    next_ctrl0 = ctrl0;
    next_ctrl1 = ctrl1;
    if (wr_fire && sel_c0) begin
      next_ctrl0 = c0_merged[15:0];
    end
    if (wr_fire && sel_c1) begin
      next_ctrl1 = c1_merged[15:0];
    end
    if (pec_clr) begin
      next_ctrl0[isx_pkg::C0_PEC_TX] = 1'b0;
    end
    if (!enabled) begin
      next_ctrl0[isx_pkg::C0_ACK] = 1'b0;
    end
    if (ev_stop_detected) begin
      next_ctrl0[isx_pkg::C0_STOP] = 1'b0;
    end
    if (tmo_hit) begin
      next_ctrl0[isx_pkg::C0_STOP] = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl0 <= isx_pkg::CTRL0_RESET;
      ctrl1 <= isx_pkg::CTRL1_RESET;
      frame_ctl <= isx_pkg::FRAME_RESET;
    end else begin
      ctrl0 <= next_ctrl0;
      ctrl1 <= next_ctrl1;
      if (wr_fire && sel_fr) begin
        frame_ctl <= {6'h00, fr_merged[1:0]};
      end
    end
  end

  //------------------------------------------------------------
  // Flags
  //------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ev_flags <= 8'h00;
      err_flags <= 8'h00;
      arp_flags <= 8'h00;
      fr_flags <= 8'h00;
    end else begin
      ev_flags <= sticky(ev_flags, {3'h0, ev_stop_detected, ev_header_sent, 1'b0,
                                    ev_address_matched, ev_start_sent}, clr_evt);
      err_flags <= sticky(err_flags, {alert_seen, tmo_hit, 1'b0, crc_bad, overrun,
                                      ev_nack, ev_arb_lost, ev_bus_error}, clr_err);
      arp_flags <= sticky(arp_flags, {1'b0,
        smbus && ctrl0[isx_pkg::C0_ARP] && ctrl0[isx_pkg::C0_ROLE] && ev_host_address,
        smbus && ctrl0[isx_pkg::C0_ARP] && !ctrl0[isx_pkg::C0_ROLE] && ev_default_address,
        5'h00}, clr_arp);
      fr_flags <= sticky(fr_flags, {out_fall, out_rise, in_fall, in_rise, 4'h0},
                         clr_fr);
    end
  end

  // Levels from the engine are included so a stalled byte also interrupts
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      event_irq <= 1'b0;
      error_irq <= 1'b0;
    end else begin
      event_irq <= ctrl1[isx_pkg::C1_EVT_IE] && ((|(ev_flags | lvl_evt)) || (|fr_flags));
      error_irq <= ctrl1[isx_pkg::C1_ERR_IE] && (|err_flags);
    end
  end

  //------------------------------------------------------------
  // Checksum, DMA, stretching, timeout, pins
  //------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      crc <= isx_pkg::CRC_INIT;
    end else if (ev_start_detected) begin
      crc <= isx_pkg::CRC_INIT;
    end else if (bus_byte_valid && ctrl0[isx_pkg::C0_PEC_EN]) begin
      crc <= crc8_step(crc, bus_byte);
    end
  end

  // End of transfer stays armed until the next message or DMA is switched off
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      eot_seen <= 1'b0;
    end else if (ev_start_detected || !dma_on) begin
      eot_seen <= 1'b0;
    end else if (dma_eot) begin
      eot_seen <= 1'b1;
    end
  end

  // Saturates so one long low period reports only once
  always_ff @(posedge aclk) begin
    if (!aresetn || !tmo_low) begin
      tmo_cnt <= 21'h00_0000;
    end else if (tmo_cnt != 21'(TIMEOUT_CYCLES)) begin
      tmo_cnt <= tmo_cnt + 21'h00_0001;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scl_oe_n <= 1'b1;
      smba_oe_n <= 1'b1;
      frame_out <= 1'b0;
      frame_out_prev <= 1'b0;
      tx_req_prev <= 1'b0;
      rx_req_prev <= 1'b0;
      dma_tx_req <= 1'b0;
      dma_rx_req <= 1'b0;
      eng_ack_enable <= 1'b0;
      eng_checksum_send <= 1'b0;
      stop_request <= 1'b0;
      checksum_value <= isx_pkg::CRC_INIT;
    end else begin
      scl_oe_n <= !stretch;
      // Frame pin owns the shared line in frame mode, so no alert drive then
      smba_oe_n <= !(smbus && !frame_en && ctrl0[isx_pkg::C0_ALERT]);
      frame_out <= frame_level;
      frame_out_prev <= frame_level;
      tx_req_prev <= tx_req_cond;
      rx_req_prev <= rx_req_cond;
      dma_tx_req <= tx_req_cond && !tx_req_prev;
      dma_rx_req <= rx_req_cond && !rx_req_prev;
      eng_ack_enable <= ctrl0[isx_pkg::C0_ACK] && !last_nack;
      eng_checksum_send <= pec_arm;
      stop_request <= next_ctrl0[isx_pkg::C0_STOP];
      checksum_value <= ev_start_detected ? isx_pkg::CRC_INIT : crc;
    end
  end

  assign scl_out = 1'b0;
  assign smba_out = 1'b0;

  //------------------------------------------------------------
  // Checks
  //------------------------------------------------------------
  AST_TX_STRETCH: assert property (@(posedge aclk) disable iff (!aresetn)
    tx_stall && !slave_no_stretch |=> !scl_oe_n) else $error("transmit stall not stretched");
  AST_RX_STRETCH: assert property (@(posedge aclk) disable iff (!aresetn)
    rx_stall && !slave_no_stretch |=> !scl_oe_n) else $error("receive stall not stretched");
  AST_NO_STRETCH: assert property (@(posedge aclk) disable iff (!aresetn)
    slave_no_stretch |=> scl_oe_n) else $error("clock held with stretching off");
  AST_DMA_REQ: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(tx_req_cond) |=> dma_tx_req ##1 !dma_tx_req) else $error("dma request not one pulse");
  AST_LAST_NACK: assert property (@(posedge aclk) disable iff (!aresetn)
    last_nack |=> !eng_ack_enable) else $error("final dma byte acknowledged");
  AST_CRC_CLEAR: assert property (@(posedge aclk) disable iff (!aresetn)
    ev_start_detected |=> crc == isx_pkg::CRC_INIT && checksum_value == isx_pkg::CRC_INIT)
    else $error("checksum not cleared at start");
  AST_TIMEOUT: assert property (@(posedge aclk) disable iff (!aresetn)
    tmo_hit |=> stop_request && err_flags[6]) else $error("timeout without stop request");
  AST_PEC_CLEAR: assert property (@(posedge aclk) disable iff (!aresetn)
    ev_start_detected || pec_byte_valid |=> !ctrl0[isx_pkg::C0_PEC_TX])
    else $error("checksum transfer bit not cleared");
  AST_FRAME_OUT: assert property (@(posedge aclk) disable iff (!aresetn)
    frame_level |=> frame_out) else $error("frame output not asserted");

endmodule : isx_aux

// [dv/isx_bus_dev.sv]
// Far-side device model: pulled-up clock and alert lines
`timescale 1ns/10ps
module isx_bus_dev (
  // Design pin enables
  input wire logic scl_oe_n,
  input wire logic smba_oe_n,
  // Scenario controls
  input wire logic run,
  input wire logic hold_low,
  input wire logic alert,
  // Resolved lines
  output logic scl_in,
  output logic smba_in
);
  logic clk_lvl = 1'b1;
  // Runs only inside a frame; 200 ns stays far above the floor rate
  always #100 clk_lvl = run ? ~clk_lvl : 1'b1;
  // Wired-AND: a released line goes to its pull-up level
  assign scl_in = clk_lvl & ~hold_low & scl_oe_n;
  assign smba_in = ~alert & smba_oe_n;
endmodule : isx_bus_dev

// [dv/isx_aux_tb.sv]
// Self-checking bench for the serial-bus auxiliary block
`timescale 1ns/10ps
module isx_aux_tb;
  localparam int TMO = 64;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [7:0] awaddr = '0, araddr = '0, bus_byte = '0, pec_byte = '0, crc;
  logic [31:0] wdata = '0, rd_d, rdata;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = '0, wvalid = '0, bready = '0, arvalid = '0, rready = '0;
  logic eng_transmitting = '0, eng_master = '0, eng_busy = '0, dma_eot = '0;
  logic tx_empty_flag = '0, rx_not_empty_flag = '0, byte_complete_flag = '0;
  logic ev_start_detected = '0, ev_host_address = '0, ev_default_address = '0;
  logic bus_byte_valid = '0, pec_byte_valid = '0, run = '0, hold = '0, alert = '0;
  logic [6:0] ev = '0;
  wire ev_start_sent = ev[0], ev_address_matched = ev[1], ev_header_sent = ev[2];
  wire ev_stop_detected = ev[3], ev_bus_error = ev[4], ev_arb_lost = ev[5], ev_nack = ev[6];
  logic awready, wready, bvalid, arready, rvalid, eng_ack_enable, eng_checksum_send;
  logic stop_request, dma_tx_req, dma_rx_req, scl_out, scl_oe_n, scl_in, smba_in;
  logic smba_out, smba_oe_n, frame_out, event_irq, error_irq;
  logic [1:0] bresp, rresp, rd_r, wr_r;
  logic [7:0] checksum_value;
  int fails = 0, n_checks = 0, dma_n = 0;
  int ebit[7] = '{0, 1, 3, 4, 8, 9, 10};
  logic [7:0] pat[3] = '{8'hA4, 8'h5C, 8'hFF};

  isx_aux #(.TIMEOUT_CYCLES(TMO)) dut (.*);
  isx_bus_dev far (.scl_oe_n(scl_oe_n), .smba_oe_n(smba_oe_n), .run(run),
    .hold_low(hold), .alert(alert), .scl_in(scl_in), .smba_in(smba_in));
  initial forever #12.5 aclk = ~aclk;
  always @(posedge aclk) dma_n <= dma_n + dma_tx_req + dma_rx_req;

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("unexpected at %0t: got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    wr_r = bresp;
  endtask : axw
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    rready <= 1'b0;
    rd_d = rdata;
    rd_r = rresp;
    chk(rd_d, e);
  endtask : rd
  task automatic feed(input logic [7:0] b);
    @(posedge aclk);
    bus_byte_valid <= 1'b1;
    bus_byte <= b;
    @(posedge aclk);
    bus_byte_valid <= 1'b0;
  endtask : feed
  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] b);
    logic [7:0] x;
    x = c ^ b;
    for (int i = 0; i < 8; i++) x = x[7] ? {x[6:0], 1'b0} ^ 8'h07 : {x[6:0], 1'b0};
    return x;
  endfunction : crc8
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : test_done

  //--------------------
  // Tests
  //--------------------
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rd(8'h20, 32'h0);
    chk(32'(rd_r), 32'h2);
    axw(8'h20, 32'h0);
    chk(32'(wr_r), 32'h2);
    axw(8'h00, 32'h1);
    chk(32'(wr_r), 32'h0);
    foreach (ebit[i]) begin
      @(posedge aclk) ev <= 7'h01 << i;
      @(posedge aclk) ev <= '0;
      rd(8'h08, 32'h1 << ebit[i]);
      axw(8'h08, 32'h0);
    end
    $display("test events done");
    axw(8'h04, 32'h800);
    @(posedge aclk);
    eng_transmitting <= 1'b1;
    tx_empty_flag <= 1'b1;
    byte_complete_flag <= 1'b1;
    repeat (3) @(posedge aclk);
    chk(32'(scl_oe_n), 32'h0);
    tx_empty_flag <= 1'b0;
    repeat (3) @(posedge aclk);
    chk(32'(scl_oe_n), 32'h1);
    eng_transmitting <= 1'b0;
    rx_not_empty_flag <= 1'b1;
    repeat (3) @(posedge aclk);
    chk(32'(scl_oe_n), 32'h0);
    chk(dma_n, 32'h2);
    rx_not_empty_flag <= 1'b0;
    byte_complete_flag <= 1'b0;
    axw(8'h04, 32'h0);
    $display("test stretch and dma done");
    axw(8'h00, 32'h21);
    feed(8'h3C);
    @(posedge aclk) ev_start_detected <= 1'b1;
    @(posedge aclk) ev_start_detected <= 1'b0;
    crc = 8'h00;
    foreach (pat[i]) begin
      feed(pat[i]);
      crc = crc8(crc, pat[i]);
    end
    rd(8'h0C, {16'h0, crc, 8'h0});
    chk(32'(checksum_value), 32'(crc));
    axw(8'h00, 32'h1021);
    @(posedge aclk);
    chk(32'(eng_checksum_send), 32'h1);
    pec_byte_valid <= 1'b1;
    pec_byte <= ~crc;
    @(posedge aclk) pec_byte_valid <= 1'b0;
    rd(8'h08, 32'h1000);
    rd(8'h00, 32'h21);
    axw(8'h08, 32'h0);
    $display("test checksum done");
    axw(8'h00, 32'h3);
    run <= 1'b1;
    repeat (200) @(posedge aclk);
    run <= 1'b0;
    rd(8'h08, 32'h0);
    hold <= 1'b1;
    repeat (TMO + 16) @(posedge aclk);
    hold <= 1'b0;
    rd(8'h08, 32'h4000);
    chk(32'(stop_request), 32'h1);
    axw(8'h00, 32'h2003);
    @(posedge aclk);
    chk(32'(smba_oe_n), 32'h0);
    axw(8'h00, 32'h3);
    axw(8'h08, 32'h0);
    alert <= 1'b1;
    repeat (6) @(posedge aclk);
    alert <= 1'b0;
    rd(8'h08, 32'h8000);
    $display("test smbus done");
    axw(8'h10, 32'h1);
    eng_master <= 1'b1;
    eng_busy <= 1'b1;
    repeat (3) @(posedge aclk);
    chk(32'(frame_out), 32'h1);
    rd(8'h10, 32'h4D);
    $display("test frame done");
    axw(8'h00, 32'h401);
    axw(8'h04, 32'h1800);
    chk(32'(eng_ack_enable), 32'h1);
    @(posedge aclk) dma_eot <= 1'b1;
    @(posedge aclk) dma_eot <= 1'b0;
    repeat (2) @(posedge aclk);
    chk(32'(eng_ack_enable), 32'h0);
    axw(8'h04, 32'h800);
    @(posedge aclk) ev <= 7'h02;
    @(posedge aclk) ev <= '0;
    axw(8'h00, 32'h1);
    @(posedge aclk);
    chk(32'(eng_ack_enable), 32'h0);
    axw(8'h08, 32'h0);
    $display("test dma last done");
    axw(8'h00, 32'h1B);
    @(posedge aclk) {ev_host_address, ev_default_address} <= 2'b11;
    @(posedge aclk) {ev_host_address, ev_default_address} <= 2'b00;
    rd(8'h0C, {16'h0, crc, 8'h40});
    axw(8'h00, 32'h13);
    @(posedge aclk) {ev_host_address, ev_default_address} <= 2'b11;
    @(posedge aclk) {ev_host_address, ev_default_address} <= 2'b00;
    rd(8'h0C, {16'h0, crc, 8'h60});
    $display("test address resolution done");
    axw(8'h04, 32'h300);
    axw(8'h00, 32'h81);
    eng_master <= 1'b0;
    eng_transmitting <= 1'b1;
    tx_empty_flag <= 1'b1;
    byte_complete_flag <= 1'b1;
    run <= 1'b1;
    repeat (20) @(posedge aclk);
    chk(32'(scl_oe_n), 32'h1);
    chk(32'({event_irq, error_irq}), 32'h3);
    {run, eng_transmitting, tx_empty_flag, byte_complete_flag} <= 4'h0;
    rd(8'h08, 32'h800);
    $display("test no stretch done");
    test_done();
  end
  initial begin
    repeat (20000) @(posedge aclk);
    fails++;
    test_done();
  end
endmodule : isx_aux_tb
